// >>> common/rst_seq_pkg.sv
// constants for the reset pin state sequencer
package rst_seq_pkg;

  // bus personality strap encodings
  typedef enum logic [1:0] {
    PERS_PCI    = 2'b00,
    PERS_ISA    = 2'b01,
    PERS_PCMCIA = 2'b10,
    PERS_LOCAL  = 2'b11
  } personality_t;

  // reset phases
  typedef enum logic [1:0] {
    PH_IN_ACTIVE  = 2'b00,
    PH_OUT_HELD   = 2'b01,
    PH_RUN        = 2'b10
  } phase_t;

  localparam logic [19:0] SA_HOLD_VALUE   = 20'hFFF03;
  localparam logic [23:0] BOOT_FETCH_ADDR = 24'hFFFFF0;
  localparam logic [19:0] SA_IDLE_VALUE   = 20'hFFFFF;
  localparam logic [7:0]  OUT_HOLD_CYCLES = 8'h10;
  localparam logic [7:0]  HOLD_CNT_RESET  = 8'h00;

endpackage

// >>> design/strap_latch.sv
// latches the bus personality straps at the end of reset input
`timescale 1ns/100ps
module strap_latch (
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       capture,
  input  wire logic [1:0]                 strap_in,
  output rst_seq_pkg::personality_t       personality
);

  // straps are static on the board; caught once on the capture pulse
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      personality <= rst_seq_pkg::PERS_PCI;
    end else if (capture) begin
      personality <= rst_seq_pkg::personality_t'(strap_in); // [R8]
    end
  end

endmodule

// >>> design/reset_pin_state_sequencer.sv
// reset pin state sequencer: drives external bus pins through reset phases
`timescale 1ns/100ps
// Functional notes
// [R1] non-local personality boots fetch over PCI
// [R2] ISA/PCMCIA boot there; address lines hold FFF03
// [R3] first fetch targets byte address FFFFF0
// [R4] card enables and supply enables high in reset
// [R5] disk read/write strobes high in reset
// [R6] disk selects low after reset input release
// [R7] flash chip selects high in reset
// [R8] personality chosen by static board straps
// [R9] bus pins time-shared with disk at run time
// [R10] three phases; pins update at boundaries
module reset_pin_state_sequencer (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        system_reset_in_n,
  input  wire logic [1:0]  strap_personality,
  input  wire logic        disk_cycle_req,
  output logic             system_reset_out_n,
  output logic             card_enable_high_n,
  output logic             card_enable_low_n,
  output logic             socket_5v_supply_enable,
  output logic             socket_3v_supply_enable,
  output logic             primary_disk_read_strobe_n,
  output logic             primary_disk_write_strobe_n,
  output logic             secondary_disk_read_strobe_n,
  output logic             secondary_disk_write_strobe_n,
  output logic             primary_disk_select_a,
  output logic             primary_disk_select_b,
  output logic             secondary_disk_select_a,
  output logic             secondary_disk_select_b,
  output logic             flash0_low_select_n,
  output logic             flash0_high_select_n,
  output logic             flash1_low_select_n,
  output logic             flash1_high_select_n,
  output logic             flash0_select_n,
  output logic             flash1_select_n,
  output logic [19:0]      system_address_lines,
  output logic             pins_owned_by_disk,
  output logic             boot_fetch_start,
  output logic             boot_fetch_on_pci,
  output logic             boot_fetch_on_ext,
  output logic [23:0]      boot_fetch_addr
);

  // ************************************************************
  // phase tracking
  // ************************************************************
  rst_seq_pkg::phase_t        phase_r;
  rst_seq_pkg::phase_t        phase_nxt;
  logic [7:0]                 hold_cnt_r;
  rst_seq_pkg::personality_t  personality;
  logic                       strap_capture;
  logic                       fetch_done_r;

  assign strap_capture = (phase_r == rst_seq_pkg::PH_IN_ACTIVE) && system_reset_in_n;

  strap_latch u_strap (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .capture     (strap_capture),
    .strap_in    (strap_personality),
    .personality (personality)
  );

  // next phase: reset input low always returns to the first phase
  always_comb begin
    phase_nxt = phase_r;
    if (!system_reset_in_n) begin
      phase_nxt = rst_seq_pkg::PH_IN_ACTIVE; // [R10]
    end else begin
      case (phase_r)
        rst_seq_pkg::PH_IN_ACTIVE: begin
          phase_nxt = rst_seq_pkg::PH_OUT_HELD; // [R10]
        end
        rst_seq_pkg::PH_OUT_HELD: begin
          if (hold_cnt_r == rst_seq_pkg::OUT_HOLD_CYCLES) begin
            phase_nxt = rst_seq_pkg::PH_RUN; // [R10]
          end
        end
        rst_seq_pkg::PH_RUN: begin
          phase_nxt = rst_seq_pkg::PH_RUN;
        end
        default: begin
          phase_nxt = rst_seq_pkg::PH_IN_ACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_r <= rst_seq_pkg::PH_IN_ACTIVE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // hold counter keeps reset output asserted a fixed time after input release
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_r != rst_seq_pkg::PH_OUT_HELD) begin
      hold_cnt_r <= rst_seq_pkg::HOLD_CNT_RESET;
    end else if (hold_cnt_r != rst_seq_pkg::OUT_HOLD_CYCLES) begin
      hold_cnt_r <= hold_cnt_r + 8'h01;
    end
  end

  // ************************************************************
  // pin levels per phase
  // ************************************************************
  // reset output stays low until the run phase is entered
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt != rst_seq_pkg::PH_RUN) begin
      system_reset_out_n <= 1'b0;
    end else begin
      system_reset_out_n <= 1'b1; // [R10]
    end
  end

  // card pins parked high in reset; later phases leave them to the card logic
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt == rst_seq_pkg::PH_IN_ACTIVE) begin
      card_enable_high_n      <= 1'b1; // [R4]
      card_enable_low_n       <= 1'b1; // [R4]
      socket_5v_supply_enable <= 1'b1; // [R4]
      socket_3v_supply_enable <= 1'b1; // [R4]
    end
  end

  // disk strobes inactive in reset so no drive sees a stray access
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt == rst_seq_pkg::PH_IN_ACTIVE) begin
      primary_disk_read_strobe_n    <= 1'b1; // [R5]
      primary_disk_write_strobe_n   <= 1'b1; // [R5]
      secondary_disk_read_strobe_n  <= 1'b1; // [R5]
      secondary_disk_write_strobe_n <= 1'b1; // [R5]
    end
  end

  // every flash select parked inactive while reset input is low
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt == rst_seq_pkg::PH_IN_ACTIVE) begin
      flash0_low_select_n  <= 1'b1; // [R7]
      flash0_high_select_n <= 1'b1; // [R7]
      flash1_low_select_n  <= 1'b1; // [R7]
      flash1_high_select_n <= 1'b1; // [R7]
      flash0_select_n      <= 1'b1; // [R7]
      flash1_select_n      <= 1'b1; // [R7]
    end
  end

  // selects may float in reset; low there too keeps them defined throughout
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt != rst_seq_pkg::PH_RUN) begin
      primary_disk_select_a   <= 1'b0; // [R6]
      primary_disk_select_b   <= 1'b0; // [R6]
      secondary_disk_select_a <= 1'b0; // [R6]
      secondary_disk_select_b <= 1'b0; // [R6]
    end
  end

  // address lines idle, then the hold pattern; run leaves them to the bus logic
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt == rst_seq_pkg::PH_IN_ACTIVE) begin
      system_address_lines <= rst_seq_pkg::SA_IDLE_VALUE;
    end else if (phase_nxt == rst_seq_pkg::PH_OUT_HELD) begin
      system_address_lines <= rst_seq_pkg::SA_HOLD_VALUE; // [R2]
    end
  end

  // ************************************************************
  // first prefetch and run-time pin sharing
  // ************************************************************
  // marks that the run phase has already been entered once
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt != rst_seq_pkg::PH_RUN) begin
      fetch_done_r <= 1'b0;
    end else begin
      fetch_done_r <= 1'b1;
    end
  end

  // one-cycle start pulse on the transition into the run phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt != rst_seq_pkg::PH_RUN) begin
      boot_fetch_start <= 1'b0;
    end else begin
      boot_fetch_start <= !fetch_done_r; // [R10]
    end
  end

  // boot address held for the whole run so a slow bus can still take it
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt != rst_seq_pkg::PH_RUN) begin
      boot_fetch_addr <= 24'h000000;
    end else begin
      boot_fetch_addr <= rst_seq_pkg::BOOT_FETCH_ADDR; // [R3]
    end
  end

  // pci carries the prefetch unless the local bus boots from flash;
  // ISA and PCMCIA also run it on their own bus
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt != rst_seq_pkg::PH_RUN) begin
      boot_fetch_on_pci <= 1'b0;
      boot_fetch_on_ext <= 1'b0;
    end else begin
      boot_fetch_on_pci <= (personality != rst_seq_pkg::PERS_LOCAL); // [R1]
      boot_fetch_on_ext <= (personality == rst_seq_pkg::PERS_ISA)
                        || (personality == rst_seq_pkg::PERS_PCMCIA); // [R2]
    end
  end

  // disk takes the shared pins only in run phase and after the boot fetch
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_nxt != rst_seq_pkg::PH_RUN) begin
      pins_owned_by_disk <= 1'b0;
    end else begin
      pins_owned_by_disk <= disk_cycle_req && fetch_done_r; // [R9]
    end
  end

endmodule

// >>> sim/rst_seq_properties.sv
// assertion checker for the reset pin state sequencer
`timescale 1ns/100ps
module rst_seq_properties (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        system_reset_in_n,
  input wire logic [1:0]  strap_personality,
  input wire logic        disk_cycle_req,
  input wire logic        system_reset_out_n,
  input wire logic        card_enable_low_n,
  input wire logic        socket_5v_supply_enable,
  input wire logic        primary_disk_write_strobe_n,
  input wire logic        secondary_disk_read_strobe_n,
  input wire logic        flash0_high_select_n,
  input wire logic        flash1_select_n,
  input wire logic        secondary_disk_select_b,
  input wire logic [19:0] system_address_lines,
  input wire logic        pins_owned_by_disk,
  input wire logic        boot_fetch_start,
  input wire logic        boot_fetch_on_pci,
  input wire logic        boot_fetch_on_ext,
  input wire logic [23:0] boot_fetch_addr
);
  // ****
  // properties
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // phase boundaries as seen at the pins
  sequence in_release; $rose(system_reset_in_n) ##1 system_reset_in_n; endsequence
  sequence out_release; $rose(system_reset_out_n); endsequence
  chk_card_high: assert property (!system_reset_in_n |=> card_enable_low_n &&
    socket_5v_supply_enable) else $error("card pins not high in reset");
  chk_strobe_high: assert property (!system_reset_in_n |=> primary_disk_write_strobe_n &&
    secondary_disk_read_strobe_n) else $error("disk strobes not high in reset");
  chk_flash_high: assert property (!system_reset_in_n |=> flash0_high_select_n &&
    flash1_select_n && !system_reset_out_n) else $error("flash selects not high in reset");
  chk_sel_low: assert property (in_release |=> !secondary_disk_select_b &&
    system_address_lines == 20'hFFF03) else $error("hold phase pins wrong");
  chk_out_timing: assert property (out_release |-> $past(system_reset_in_n, 18) &&
    !$past(system_reset_in_n, 19)) else $error("reset output released at wrong time");
  chk_fetch_pulse: assert property (out_release |-> boot_fetch_start &&
    boot_fetch_addr == 24'hFFFFF0 ##1 !boot_fetch_start) else $error("boot fetch pulse wrong");
  chk_fetch_bus: assert property (out_release |->
    boot_fetch_on_pci == (strap_personality != 2'h3) &&
    boot_fetch_on_ext == (strap_personality inside {2'h1, 2'h2}))
    else $error("fetch bus wrong");
  chk_disk_share: assert property (system_reset_out_n && $past(system_reset_out_n, 3) |->
    pins_owned_by_disk == $past(disk_cycle_req)) else $error("disk pin sharing wrong");
  chk_run_hold: assert property (system_reset_out_n && $past(system_reset_out_n) |->
    $stable(system_address_lines)) else $error("address lines moved in run");
endmodule
bind reset_pin_state_sequencer rst_seq_properties rst_seq_properties_i (.*);

// >>> sim/boot_mem_model.sv
// boot memory model that records the first fetch on the selected bus
`timescale 1ns/100ps
module boot_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        fetch_start,
  input  wire logic        on_pci,
  input  wire logic        on_ext,
  input  wire logic [23:0] fetch_addr,
  output logic [23:0]      seen_addr,
  output logic [7:0]       fetch_count
);
  // ****
  // address phase capture
  // ****
  // every cycle with fetch_start high is counted unless on_ext is high without on_pci, so it must be a pulse; a level would count one fetch many times
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fetch_count <= 8'h00;
      seen_addr   <= 24'h000000;
    // an ISA or PCMCIA fetch that skipped PCI never reaches the boot memory
    end else if (fetch_start && (on_pci || !on_ext)) begin
      seen_addr   <= fetch_addr;
      fetch_count <= fetch_count + 8'h01;
    end
  end
endmodule

// >>> sim/tb.sv
// self-checking testbench for the reset pin state sequencer
`timescale 1ns/100ps
module tb;
  logic sys_clk, sys_rst, system_reset_in_n, disk_cycle_req, system_reset_out_n;
  logic [1:0] strap_personality;
  logic card_enable_high_n, card_enable_low_n, socket_5v_supply_enable, socket_3v_supply_enable;
  logic primary_disk_read_strobe_n, primary_disk_write_strobe_n, secondary_disk_read_strobe_n;
  logic secondary_disk_write_strobe_n, primary_disk_select_a, primary_disk_select_b;
  logic secondary_disk_select_a, secondary_disk_select_b, flash0_low_select_n, flash0_select_n;
  logic flash0_high_select_n, flash1_low_select_n, flash1_high_select_n, flash1_select_n;
  logic pins_owned_by_disk, boot_fetch_start, boot_fetch_on_pci, boot_fetch_on_ext;
  logic [19:0] system_address_lines;
  logic [23:0] boot_fetch_addr, seen_addr;
  logic [7:0] fetch_count;
  logic [14:0] hold_v;
  logic [3:0] sel_v;
  logic [2:0] bus_v;
  int fail_count = 0;
  int n_checks = 0;
  // ****
  // harness
  // ****
  assign hold_v = {card_enable_high_n, card_enable_low_n, socket_5v_supply_enable,
    socket_3v_supply_enable, primary_disk_read_strobe_n, primary_disk_write_strobe_n,
    secondary_disk_read_strobe_n, secondary_disk_write_strobe_n, flash0_low_select_n,
    flash0_high_select_n, flash1_low_select_n, flash1_high_select_n, flash0_select_n,
    flash1_select_n, system_reset_out_n};
  assign sel_v = {primary_disk_select_a, primary_disk_select_b, secondary_disk_select_a,
    secondary_disk_select_b};
  assign bus_v = {boot_fetch_on_ext, boot_fetch_on_pci, system_reset_out_n};
  reset_pin_state_sequencer reset_pin_state_sequencer_i (.*);
  boot_mem_model boot_mem_model_i (.sys_clk, .sys_rst, .fetch_start(boot_fetch_start),
    .on_pci(boot_fetch_on_pci), .on_ext(boot_fetch_on_ext), .fetch_addr(boot_fetch_addr),
    .seen_addr, .fetch_count);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hold reset input with new straps, then release and time the boot fetch
  task automatic boot_case(input logic [1:0] s);
    int n;
    logic [2:0] eb;
    logic [7:0] count_was;
    eb = {(s == 2'h1) || (s == 2'h2), s != 2'h3, 1'b1};
    count_was = fetch_count;
    @(posedge sys_clk);
    system_reset_in_n <= 1'b0;
    strap_personality <= s; // straps stay static through the whole boot
    repeat (3) @(posedge sys_clk);
    #1;
    chk("reset pins", 24'(hold_v), 24'h007FFE);
    @(posedge sys_clk);
    system_reset_in_n <= 1'b1;
    n = 0;
    while (boot_fetch_start !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n == 2) chk("hold phase", 24'({sel_v, system_address_lines}), 24'h0FFF03);
    end
    if (n >= 40) begin
      fail_count++;
      finish_test();
    end
    chk("fetch cycle", 24'(n), 24'(rst_seq_pkg::OUT_HOLD_CYCLES) + 24'h000002);
    chk("fetch bus", 24'(bus_v), 24'(eb));
    @(posedge sys_clk);
    #1;
    chk("fetch addr", seen_addr, 24'hFFFFF0);
    chk("fetch count", 24'(fetch_count), 24'(count_was) + 24'h000001);
  endtask
  // disk controller takes and gives back the shared pins in run
  task automatic disk_case;
    @(posedge sys_clk);
    disk_cycle_req <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("disk owns", 24'(pins_owned_by_disk), 24'h000001);
    @(posedge sys_clk);
    disk_cycle_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("disk frees", 24'(pins_owned_by_disk), 24'h000000);
  endtask
  // release cut short mid-count must not boot
  task automatic abort_case;
    logic [7:0] count_was;
    count_was = fetch_count;
    @(posedge sys_clk);
    system_reset_in_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    system_reset_in_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    system_reset_in_n <= 1'b0;
    repeat (30) @(posedge sys_clk);
    #1;
    chk("abort pins", 24'({sel_v, hold_v}), 24'h007FFE);
    chk("abort fetch", 24'(fetch_count), 24'(count_was));
  endtask
  initial begin
    sys_rst = 1'b1;
    system_reset_in_n = 1'b0;
    strap_personality = 2'h0;
    disk_cycle_req = 1'b0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    boot_case(2'h0);
    disk_case();
    boot_case(2'h1);
    boot_case(2'h2);
    boot_case(2'h3);
    abort_case();
    finish_test();
  end
endmodule
